/* hw/adc_ctl_pkg.sv */
// Purpose: Shared constants and types for the converter control block
// Assumes: 100 MHz system clock, control bits arrive as plain ports
// Notes: Analog front end is modelled by a sample input only; conversion end is timed by divider ticks
package adc_ctl_pkg;
    localparam int NUM_PINS = 4;
    localparam int RESULT_W = 12;
    localparam int DIV_W = 3;
    localparam int CONV_PERIODS = 16;
    localparam logic [3:0] PIN_ENABLE_RST = 4'hF;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] DIV_UNDEFINED = 3'h7;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [4:0] CONV_COUNT_LAST = 5'(CONV_PERIODS - 1);
    localparam logic [5:0] PRESCALE_RST = 6'h00;
    localparam logic [2:0] SYNC_RST = 3'h0;
    typedef enum logic [1:0] {ST_IDLE, ST_HELD, ST_CONVERT} conv_state_t;
endpackage

/* hw/adc_link_if.sv */
// Purpose: Carries the tick handshake between control core and clock divider
// Assumes: Single clock domain
// Notes: Divider is restarted at each conversion start so periods align
`timescale 1ns/1ps
interface adc_link_if;
    logic [2:0] div_code;
    logic restart;
    logic tick;
    modport core (output div_code, output restart, input tick);
    modport div (input div_code, input restart, output tick);
endinterface

/* hw/conv_clock_divider.sv */
// Purpose: Produces one tick per divided conversion clock period
// Assumes: Codes 0..6 select divide by 1..64
// Notes: Code 7 is undefined; it is treated here as divide by 64
`timescale 1ns/1ps
module conv_clock_divider (
    input wire logic mclk,
    input wire logic rst_n,
    adc_link_if.div link
);
    logic [5:0] count_r;
    logic [5:0] count_nxt;
    logic tick_r;
    logic [5:0] limit;
    logic at_limit;

    // Undefined code falls back to the slowest ratio to stay harmless
    assign limit = (link.div_code == adc_ctl_pkg::DIV_UNDEFINED) ? 6'h3F
                 : 6'((7'h01 << link.div_code) - 7'h01); // [R05]
    assign at_limit = (count_r >= limit);
    assign count_nxt = (link.restart || at_limit) ? adc_ctl_pkg::PRESCALE_RST
                     : 6'(count_r + 6'h01);
    assign link.tick = tick_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= adc_ctl_pkg::PRESCALE_RST;
            tick_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r <= at_limit && !link.restart;
        end
    end
endmodule // conv_clock_divider

/* hw/adc_conversion_control.sv */
// Purpose: Control logic of a 12-bit converter: pins, reference, clock, start, result
// Assumes: Control bits are plain ports from the core; start comes from same clock
// Notes: Analog sample arrives as a 12-bit word from the analog macro through a synchroniser
// Summary of operation
// R01: Set pin enable routes that pin to converter, other functions off.
// R02: Pull-high resistor disconnected while pin is an analog input.
// R03: Analog selection overrides port direction bit for that pin.
// R04: Reference select picks supply or reference pin; pin functions disabled.
// R05: Divider codes 0..6 give ratios 1..64; code 7 undefined.
// R06: Power-off bit high switches converter off; low powers it up.
// R07: One channel connected, chosen by upper and lower select bits.
// R08: Upper zero, lower codes 0..3 select external channels 0..3.
// R09: Start low-high-low pulse from cleared state begins conversion.
// R10: Start held high keeps converter reset and busy flag high.
// R11: Busy flag high during conversion, falls automatically at end.
// R12: Conversion lasts sixteen divided clock periods from start pulse.
// R13: Result readable in low and high result registers at completion.
// R14: Result updates only on completion and holds until next.
// R15: Result is 12-bit unsigned, full scale equals reference.
// R16: Interrupt request flag set at end of each conversion.
// R17: Interrupt delivered only when global and converter enables high.
// R18: After reset all shared pins default to converter inputs.
`timescale 1ns/1ps
module adc_conversion_control #(
    parameter int NUM_PINS = adc_ctl_pkg::NUM_PINS,
    parameter int RESULT_W = adc_ctl_pkg::RESULT_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pin_enable_wr,
    input wire logic [NUM_PINS-1:0] pin_enable_wdata,
    input wire logic [NUM_PINS-1:0] port_a_direction_reg,
    input wire logic [NUM_PINS-1:0] port_pull_high_en,
    input wire logic reference_source_select,
    input wire logic [2:0] conversion_clock_divider,
    input wire logic converter_power_off,
    input wire logic channel_select_upper,
    input wire logic [1:0] channel_select_lower,
    input wire logic start_bit,
    input wire logic global_interrupt_enable,
    input wire logic conversion_interrupt_enable,
    input wire logic flag_clear,
    input wire logic [RESULT_W-1:0] analog_sample,
    output logic [NUM_PINS-1:0] analog_pin_select_reg,
    output logic [NUM_PINS-1:0] pin_analog_route,
    output logic [NUM_PINS-1:0] pin_digital_enable,
    output logic [NUM_PINS-1:0] pin_input_force,
    output logic [NUM_PINS-1:0] pin_pull_high_active,
    output logic ref_pin_selected,
    output logic ref_pin_digital_enable,
    output logic converter_power_on,
    output logic converter_reset,
    output logic [2:0] channel_mux_sel,
    output logic channel_valid,
    output logic conversion_busy_flag,
    output logic [7:0] result_low_reg,
    output logic [7:0] result_high_reg,
    output logic conversion_interrupt_flag,
    output logic interrupt_request
);
    adc_link_if link();

    conv_clock_divider u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .link(link)
    );

    adc_ctl_pkg::conv_state_t state_r;
    adc_ctl_pkg::conv_state_t state_nxt;
    logic [NUM_PINS-1:0] pin_en_r;
    logic start_d_r;
    logic [4:0] tick_count_r;
    logic [RESULT_W-1:0] sync1_r;
    logic [RESULT_W-1:0] sync2_r;
    logic [RESULT_W-1:0] sync3_r;
    logic [RESULT_W-1:0] result_r;
    logic flag_r;
    logic busy_r;

    // Per-pin routing, reference, power, channel and interrupt outputs, all registered
    logic [NUM_PINS-1:0] route_r;
    logic [NUM_PINS-1:0] dig_en_r;
    logic [NUM_PINS-1:0] force_in_r;
    logic [NUM_PINS-1:0] pull_r;
    logic ref_sel_r;
    logic ref_dig_r;
    logic pwr_r;
    logic rst_conv_r;
    logic [2:0] mux_r;
    logic mux_valid_r;
    logic irq_r;

    wire start_rise = start_bit && !start_d_r;
    wire start_fall = !start_bit && start_d_r;
    wire last_tick = link.tick && (tick_count_r == adc_ctl_pkg::CONV_COUNT_LAST);
    wire conv_done = (state_r == adc_ctl_pkg::ST_CONVERT) && last_tick;
    wire [2:0] mux_sel = {channel_select_upper, channel_select_lower}; // [R07]
    wire mux_ok = !channel_select_upper; // [R08]
    wire flag_nxt = conv_done || (flag_r && !flag_clear); // [R16]
    // Sample words settle well before conversion end, so the two later stages agreeing is valid
    wire sample_stable = (sync2_r == sync3_r);

    assign link.div_code = conversion_clock_divider; // [R05]
    assign link.restart = (state_r != adc_ctl_pkg::ST_CONVERT);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adc_ctl_pkg::ST_IDLE: begin
                if (start_rise) begin
                    state_nxt = adc_ctl_pkg::ST_HELD; // [R10]
                end
            end
            adc_ctl_pkg::ST_HELD: begin
                if (start_fall) begin
                    state_nxt = adc_ctl_pkg::ST_CONVERT; // [R09]
                end
            end
            adc_ctl_pkg::ST_CONVERT: begin
                if (start_rise) begin
                    state_nxt = adc_ctl_pkg::ST_HELD; // [R10]
                end else if (last_tick) begin
                    state_nxt = adc_ctl_pkg::ST_IDLE; // [R11]
                end
            end
            default: state_nxt = adc_ctl_pkg::ST_IDLE;
        endcase
        // Powered-off converter cannot run a cycle
        if (converter_power_off) begin
            state_nxt = adc_ctl_pkg::ST_IDLE; // [R06]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= adc_ctl_pkg::ST_IDLE;
            start_d_r <= 1'b0;
            tick_count_r <= 5'h00;
        end else begin
            state_r <= state_nxt;
            start_d_r <= start_bit;
            if (state_r != adc_ctl_pkg::ST_CONVERT) begin
                tick_count_r <= 5'h00;
            end else if (link.tick) begin
                tick_count_r <= 5'(tick_count_r + 5'h01); // [R12]
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_en_r <= adc_ctl_pkg::PIN_ENABLE_RST; // [R18]
        end else if (pin_enable_wr) begin
            pin_en_r <= pin_enable_wdata;
        end
    end

    // Analog sample crosses from the analog macro: three stages
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= adc_ctl_pkg::RESULT_RST;
            sync2_r <= adc_ctl_pkg::RESULT_RST;
            sync3_r <= adc_ctl_pkg::RESULT_RST;
        end else begin
            sync1_r <= analog_sample;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= adc_ctl_pkg::RESULT_RST;
        end else if (conv_done && sample_stable) begin
            result_r <= sync3_r; // [R13] [R14] [R15]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
            busy_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt; // [R16]
            busy_r <= (state_nxt != adc_ctl_pkg::ST_IDLE); // [R10] [R11]
            irq_r <= flag_nxt && global_interrupt_enable
                     && conversion_interrupt_enable; // [R17]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            route_r <= adc_ctl_pkg::PIN_ENABLE_RST;
            dig_en_r <= '0;
            force_in_r <= adc_ctl_pkg::PIN_ENABLE_RST;
            pull_r <= '0;
            ref_sel_r <= 1'b0;
            ref_dig_r <= 1'b1;
            pwr_r <= 1'b0;
            rst_conv_r <= 1'b1;
            mux_r <= 3'h0;
            mux_valid_r <= 1'b1;
        end else begin
            route_r <= pin_en_r; // [R01]
            dig_en_r <= ~pin_en_r; // [R01]
            force_in_r <= pin_en_r | port_a_direction_reg; // [R03]
            pull_r <= port_pull_high_en & ~pin_en_r; // [R02]
            ref_sel_r <= reference_source_select; // [R04]
            ref_dig_r <= !reference_source_select; // [R04]
            pwr_r <= !converter_power_off; // [R06]
            rst_conv_r <= (state_nxt == adc_ctl_pkg::ST_HELD) || converter_power_off; // [R10]
            mux_r <= mux_sel; // [R07]
            mux_valid_r <= mux_ok; // [R08]
        end
    end

    assign analog_pin_select_reg = pin_en_r;
    assign pin_analog_route = route_r;
    assign pin_digital_enable = dig_en_r;
    assign pin_input_force = force_in_r;
    assign pin_pull_high_active = pull_r;
    assign ref_pin_selected = ref_sel_r;
    assign ref_pin_digital_enable = ref_dig_r;
    assign converter_power_on = pwr_r;
    assign converter_reset = rst_conv_r;
    assign channel_mux_sel = mux_r;
    assign channel_valid = mux_valid_r;
    assign conversion_busy_flag = busy_r;
    assign result_low_reg = result_r[7:0];
    assign result_high_reg = {4'h0, result_r[11:8]};
    assign conversion_interrupt_flag = flag_r;
    assign interrupt_request = irq_r;
endmodule // adc_conversion_control

/* verification/adc_ctl_monitor.sv */
// Purpose: Port-level checks of the converter control block
// Assumes: One clock, asynchronous active-low reset
// Notes: Conversion bound leaves room for the slowest divide code
`timescale 1ns/1ps
module adc_ctl_monitor #(
    parameter int NUM_PINS = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [NUM_PINS-1:0] pin_analog_route,
    input wire logic [NUM_PINS-1:0] pin_digital_enable,
    input wire logic [NUM_PINS-1:0] pin_pull_high_active,
    input wire logic reference_source_select,
    input wire logic ref_pin_selected,
    input wire logic ref_pin_digital_enable,
    input wire logic converter_power_off,
    input wire logic converter_power_on,
    input wire logic converter_reset,
    input wire logic start_bit,
    input wire logic global_interrupt_enable,
    input wire logic conversion_interrupt_enable,
    input wire logic conversion_busy_flag,
    input wire logic [7:0] result_low_reg,
    input wire logic [7:0] result_high_reg,
    input wire logic conversion_interrupt_flag,
    input wire logic interrupt_request
);
    // Busy run length; a delay range cannot span the slowest conversion
    logic [10:0] busy_len_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_len_r <= 11'h000;
        end else if (conversion_busy_flag) begin
            busy_len_r <= 11'(busy_len_r + 11'h001);
        end else begin
            busy_len_r <= 11'h000;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_go;
        $fell(start_bit) && conversion_busy_flag && !converter_power_off;
    endsequence
    sequence s_busy_run;
        conversion_busy_flag [*8] ##1 conversion_busy_flag [*7];
    endsequence
    AST_PIN_ROUTE: assert property (pin_digital_enable == ~pin_analog_route)
        else $error("digital enable not inverse of route");
    AST_PULL_OFF: assert property ((pin_pull_high_active & pin_analog_route) == '0)
        else $error("pull-high left on an analog pin");
    AST_REF_PIN: assert property ($past(rst_n) |->
        ref_pin_selected == $past(reference_source_select)
        && ref_pin_digital_enable != ref_pin_selected) else $error("reference pin wrong");
    AST_POWER: assert property ($past(rst_n) |->
        converter_power_on != $past(converter_power_off)) else $error("power state wrong");
    AST_HELD: assert property ($rose(start_bit) && !converter_power_off |=>
        conversion_busy_flag && converter_reset) else $error("start rise not held");
    // Fifteen cycles is the floor at divide by one; only power-off at the start fall is excluded, a later abort is not
    AST_CONV_LEN: assert property (s_go |-> s_busy_run)
        else $error("conversion length wrong");
    AST_CONV_END: assert property (busy_len_r < 11'h44C)
        else $error("busy flag never fell");
    AST_FLAG_END: assert property ($fell(conversion_busy_flag) && !converter_power_off
        |-> conversion_interrupt_flag) else $error("flag not set at end");
    AST_IRQ: assert property (interrupt_request == (conversion_interrupt_flag
        && $past(global_interrupt_enable) && $past(conversion_interrupt_enable)))
        else $error("interrupt gating wrong");
    AST_RESULT_HOLD: assert property (!$fell(conversion_busy_flag) |->
        $stable(result_low_reg) && $stable(result_high_reg) && result_high_reg[7:4] == 4'h0)
        else $error("result changed without completion");
endmodule // adc_ctl_monitor

bind adc_conversion_control adc_ctl_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.*);

/* verification/analog_source_model.sv */
// Purpose: Analog sources on the four shared input pins
// Assumes: Each channel holds a fixed code while selected
// Notes: An unselected or unpowered input wanders so a stale word cannot pass
`timescale 1ns/1ps
module analog_source_model #(
    parameter logic [47:0] LEVELS = 48'h0
) (
    input wire logic mclk,
    input wire logic [2:0] channel_mux_sel,
    input wire logic channel_valid,
    input wire logic converter_power_on,
    output logic [11:0] analog_sample
);
    logic [11:0] wander_r = 12'h5A5;
    always @(posedge mclk) begin
        wander_r <= ~wander_r;
    end
    assign analog_sample = (channel_valid && converter_power_on)
        ? LEVELS[channel_mux_sel[1:0]*12 +: 12] : wander_r;
endmodule // analog_source_model

/* verification/testbench.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Divide codes 0..6 only; code 7 is left alone as undefined
// Notes: Conversion length is accepted within three cycles of pipeline slack
`timescale 1ns/1ps
module testbench;
    localparam logic [47:0] LEVELS = 48'hFFF800001A5C;
    logic mclk = 1'b0, rst_n = 1'b0, pin_enable_wr = 1'b0, flag_clear = 1'b0;
    logic [3:0] pin_enable_wdata = 4'h0, port_a_direction_reg = 4'h0, port_pull_high_en = 4'hF;
    logic reference_source_select = 1'b0, converter_power_off = 1'b0, channel_select_upper = 1'b0;
    logic [2:0] conversion_clock_divider = 3'h0;
    logic [1:0] channel_select_lower = 2'h0;
    logic start_bit = 1'b0, global_interrupt_enable = 1'b0, conversion_interrupt_enable = 1'b0;
    logic [11:0] analog_sample, last_e;
    logic [3:0] analog_pin_select_reg, pin_analog_route, pin_digital_enable;
    logic [3:0] pin_input_force, pin_pull_high_active;
    logic ref_pin_selected, ref_pin_digital_enable, converter_power_on, converter_reset;
    logic channel_valid, conversion_busy_flag, conversion_interrupt_flag, interrupt_request;
    logic [2:0] channel_mux_sel;
    logic [7:0] result_low_reg, result_high_reg;
    int bad_count = 0, n_tests = 0, cyc = 0;
    adc_conversion_control uut (.*);
    analog_source_model #(.LEVELS(LEVELS)) src (.*);
    always #5 mclk = ~mclk;
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic t_pins;
        chk(analog_pin_select_reg, 4'hF);
        chk(pin_pull_high_active, 4'h0);
        @(posedge mclk);
        pin_enable_wr <= 1'b1;
        pin_enable_wdata <= 4'h5;
        @(posedge mclk);
        pin_enable_wr <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 chk(pin_analog_route, 4'h5);
        chk(pin_digital_enable, 4'hA);
        chk(pin_pull_high_active, 4'hA);
        chk(pin_input_force, 4'h5);
    endtask
    task automatic t_ref_power;
        reference_source_select <= 1'b1;
        converter_power_off <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk(ref_pin_selected, 1'b1);
        chk(converter_power_on, 1'b0);
        start_bit <= 1'b1;
        @(posedge mclk);
        start_bit <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 chk(conversion_busy_flag, 1'b0);
        converter_power_off <= 1'b0;
        reference_source_select <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_conv(input logic [2:0] div, input logic [1:0] ch, input int hold);
        int n;
        n = 0;
        last_e = LEVELS[ch*12 +: 12];
        conversion_clock_divider <= div;
        channel_select_lower <= ch;
        flag_clear <= 1'b1;
        @(posedge mclk);
        flag_clear <= 1'b0;
        start_bit <= 1'b1;
        repeat (hold) @(posedge mclk);
        #1 chk(conversion_busy_flag, 1'b1);
        chk(converter_reset, 1'b1);
        chk(channel_mux_sel, {1'b0, ch});
        start_bit <= 1'b0;
        while (conversion_busy_flag === 1'b1 && n < 1100) begin
            @(posedge mclk);
            n++;
            #1;
        end
        // Busy must fall within three cycles after sixteen divided periods
        chk(12'(n >= (16 << div) && n <= (16 << div) + 3), 12'h1);
        chk(result_low_reg, last_e[7:0]);
        chk(result_high_reg, {4'h0, last_e[11:8]});
        chk(conversion_interrupt_flag, 1'b1);
    endtask
    task automatic t_irq;
        channel_select_lower <= channel_select_lower + 2'h1;
        for (int i = 0; i < 4; i++) begin
            global_interrupt_enable <= i[1];
            conversion_interrupt_enable <= i[0];
            repeat (3) @(posedge mclk);
            #1 chk(interrupt_request, 12'(i == 3));
        end
        chk(result_low_reg, last_e[7:0]);
        flag_clear <= 1'b1;
        @(posedge mclk);
        flag_clear <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(interrupt_request, 1'b0);
        channel_select_upper <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk(channel_valid, 1'b0);
        chk(channel_mux_sel, {1'b1, channel_select_lower});
        channel_select_upper <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(channel_valid, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_pins();
        t_ref_power();
        for (int d = 0; d < 7; d++) begin
            t_conv(d[2:0], d[1:0], 1 + d);
        end
        t_irq();
        final_report();
    end
endmodule // testbench
